/* File: rtl/vsi_afifo.sv */
module vsi_afifo #(
   parameter int unsigned W  = 8,
   parameter int unsigned AW = 4
)(
   // write side
   input  wire logic         wr_clk_i,
   input  wire logic         wr_rst_i,
   input  wire logic         wr_valid_i,
   input  wire logic [W-1:0] wr_data_i,
   output logic              wr_ready_o,
   // read side
   input  wire logic         rd_clk_i,
   input  wire logic         rd_rst_i,
   output logic              rd_valid_o,
   output logic      [W-1:0] rd_data_o,
   input  wire logic         rd_ready_i
);

   generate
      if (AW < 2)
      begin : g_bad_aw
         $error("vsi_afifo needs AW of at least 2");
      end
   endgenerate

   logic [W-1:0] mem [2**AW];
   logic [AW:0]  wbin, wgray, rbin, rgray, rgray_w, wgray_r, next_wbin, next_rbin;
   logic         push, pop;

   function automatic logic [AW:0] to_gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction

   // full compares against the read pointer seen two flops late: pessimistic, never overruns
   assign wr_ready_o = (wgray != {~rgray_w[AW:AW-1], rgray_w[AW-2:0]});
   assign rd_valid_o = (rgray != wgray_r);
   assign rd_data_o  = mem[rbin[AW-1:0]];
   assign push       = wr_valid_i & wr_ready_o;
   assign pop        = rd_valid_o & rd_ready_i;

   always_comb
   begin
      next_wbin = wbin + {{AW{1'h0}}, push};
      next_rbin = rbin + {{AW{1'h0}}, pop};
   end

   always_ff @(posedge wr_clk_i or posedge wr_rst_i)
   begin
      if (wr_rst_i)
      begin
         wbin  <= '0;
         wgray <= '0;
      end
      else
      begin
         wbin  <= next_wbin;
         wgray <= to_gray(next_wbin);
      end
   end

   always_ff @(posedge wr_clk_i)
   begin
      if (push)
         mem[wbin[AW-1:0]] <= wr_data_i;
   end

   always_ff @(posedge rd_clk_i or posedge rd_rst_i)
   begin
      if (rd_rst_i)
      begin
         rbin  <= '0;
         rgray <= '0;
      end
      else
      begin
         rbin  <= next_rbin;
         rgray <= to_gray(next_rbin);
      end
   end

   vsi_sync #(.W(AW+1)) u_rptr (.clk_i(wr_clk_i), .rst_i(wr_rst_i), .d_i(rgray), .q_o(rgray_w));
   vsi_sync #(.W(AW+1)) u_wptr (.clk_i(rd_clk_i), .rst_i(rd_rst_i), .d_i(wgray), .q_o(wgray_r));

endmodule

/* File: rtl/vsi_pkg.sv */
package vsi_pkg;

   // control port word offsets
   localparam int unsigned VSI_OFS_W    = 4;
   localparam int unsigned VSI_BUS_W    = 32;
   localparam logic [3:0]  VSI_OFS_CTRL = 4'h0;
   localparam logic [3:0]  VSI_OFS_STAT = 4'h1;
   localparam logic [3:0]  VSI_OFS_IRQ  = 4'h2;
   localparam logic [3:0]  VSI_OFS_STD  = 4'h3;
   localparam logic [3:0]  VSI_OFS_DIV  = 4'h4;

   // control register fields
   localparam int unsigned VSI_CTRL_GO     = 0;
   localparam int unsigned VSI_CTRL_IRQ_EN = 1;
   localparam int unsigned VSI_CTRL_W      = 2;

   // status register fields
   localparam int unsigned VSI_ST_LOCK  = 0;
   localparam int unsigned VSI_ST_OVF   = 1;
   localparam int unsigned VSI_ST_FIELD = 2;
   localparam int unsigned VSI_ST_PLANE = 3;
   localparam int unsigned VSI_ST_HSYNC = 4;

   // interrupt register fields
   localparam int unsigned VSI_IRQ_UPD = 0;

   // reset values
   localparam logic [1:0] VSI_CTRL_RST_ON  = 2'h0;
   localparam logic [1:0] VSI_CTRL_RST_OFF = 2'h1;

   // video side frame tracking
   typedef enum logic [1:0]
   {
      VSI_WAIT  = 2'h1,
      VSI_FRAME = 2'h2
   } vsi_frame_t;

endpackage

/* File: rtl/vsi_sync.sv */
module vsi_sync #(
   parameter int unsigned W = 1
)(
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // level in and out
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] stage1;

   // stage1 feeds only the second flop
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         stage1 <= '0;
         q_o    <= '0;
      end
      else
      begin
         stage1 <= d_i;
         q_o    <= stage1;
      end
   end

endmodule

/* File: rtl/vsi_top.sv */
// Overview of operation
// - async active-high reset, synchronous release
// - video inputs sampled on video clock
// - stream and control ports on stream clock
// - first beat sop, last beat eop
// - valid only with data; sink raises ready
// - overflow output mirrors sticky bit only when control port enabled, video-clocked
// - reference clock divided by programmed ratio
// - frame-start rising edge marks frame start
// - frame-start valid high only when trustworthy
// - interrupt raised after lock or overflow status changes
// - samples accepted only while qualifier high
// - plane select low sequential, high parallel
// - video standard readable in standard register
// - control port exists only when enabled
// - control address is a word offset
// - write strobe stores write bus
// - read strobe returns addressed register
module vsi_top
   import vsi_pkg::*;
#(
   parameter int unsigned DATA_W   = 20,
   parameter int unsigned STD_W    = 3,
   parameter int unsigned DIV_W    = 12,
   parameter int unsigned FIFO_AW  = 4,
   parameter bit          USE_CTRL = 1'h1
)(
   // clocks and reset
   input  wire logic                 clk_i,
   input  wire logic                 reset_i,
   input  wire logic                 vid_clk_i,
   // video input
   input  wire logic [DATA_W-1:0]    vid_sample_i,
   input  wire logic                 sample_valid_i,
   input  wire logic                 vid_lock_i,
   input  wire logic [STD_W-1:0]     vid_standard_i,
   input  wire logic                 field_i,
   input  wire logic                 hsync_i,
   input  wire logic                 vsync_i,
   input  wire logic                 plane_format_select_i,
   // control port
   input  wire logic [VSI_OFS_W-1:0] control_word_offset_i,
   input  wire logic                 control_read_strobe_i,
   input  wire logic                 control_write_strobe_i,
   input  wire logic [VSI_BUS_W-1:0] control_write_bus_i,
   output logic      [VSI_BUS_W-1:0] control_read_bus_o,
   output logic                      status_update_irq_o,
   // stream output
   output logic      [DATA_W-1:0]    stream_pixel_out_o,
   output logic                      stream_frame_first_o,
   output logic                      stream_frame_last_o,
   output logic                      stream_beat_valid_o,
   input  wire logic                 stream_sink_ready_i,
   // video side outputs
   output logic                      overflow_o,
   output logic                      refclk_div_o,
   output logic                      frame_start_o,
   output logic                      frame_start_valid_o
);

   generate
      if (STD_W > VSI_BUS_W - 1 || DIV_W > VSI_BUS_W - 1 || DIV_W < 2 || DATA_W < 1)
      begin : g_bad_param
         $error("vsi_top parameter out of range");
      end
   endgenerate

   localparam int unsigned FW = DATA_W + 2;
   localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);
   localparam logic [DIV_W-1:0] DIV_TWO = DIV_W'(2);

   // reset synchronisers, one per domain
   logic [1:0] rst_pipe, vrst_pipe;
   logic       rst, vrst;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         rst_pipe <= 2'h3;
      else
         rst_pipe <= {rst_pipe[0], 1'h0};
   end

   always_ff @(posedge vid_clk_i or posedge reset_i)
   begin
      if (reset_i)
         vrst_pipe <= 2'h3;
      else
         vrst_pipe <= {vrst_pipe[0], 1'h0};
   end

   assign rst  = rst_pipe[1];
   assign vrst = vrst_pipe[1];

   // video domain: inputs already on this clock, one register stage
   logic [DATA_W-1:0] v_data;
   logic [STD_W-1:0]  v_std;
   logic              v_dv, v_lock, v_lock_d, v_vs, v_vs_d, v_field, v_pfs, v_hs;

   always_ff @(posedge vid_clk_i or posedge vrst)
   begin
      if (vrst)
      begin
         v_data   <= '0;
         v_std    <= '0;
         v_dv     <= 1'h0;
         v_lock   <= 1'h0;
         v_lock_d <= 1'h0;
         v_vs     <= 1'h0;
         v_vs_d   <= 1'h0;
         v_field  <= 1'h0;
         v_pfs    <= 1'h0;
         v_hs     <= 1'h0;
      end
      else
      begin
         v_data   <= vid_sample_i;
         v_std    <= vid_standard_i;
         v_dv     <= sample_valid_i;
         v_lock   <= vid_lock_i;
         v_lock_d <= v_lock;
         v_vs     <= vsync_i;
         v_vs_d   <= v_vs;
         v_field  <= field_i;
         v_pfs    <= plane_format_select_i;
         v_hs     <= hsync_i;
      end
   end

   // crossings
   logic [2:0] to_vid, from_stream;   // {div toggle, overflow sticky, go}
   logic [1:0] to_str, from_vid;      // {std toggle, overflow toggle}
   logic [3:0] lvl_to_str, lvl_str;   // {hsync, plane select, field, lock}
   logic       v_go, v_div_tog;

   assign v_go       = from_stream[0];
   assign overflow_o = from_stream[1];
   assign v_div_tog  = from_stream[2];
   assign lvl_to_str = {v_hs, v_pfs, v_field, v_lock};

   vsi_sync #(.W(3)) u_s2v (.clk_i(vid_clk_i), .rst_i(vrst), .d_i(to_vid), .q_o(from_stream));
   vsi_sync #(.W(2)) u_v2s (.clk_i(clk_i), .rst_i(rst), .d_i(to_str), .q_o(from_vid));
   vsi_sync #(.W(4)) u_lvl (.clk_i(clk_i), .rst_i(rst), .d_i(lvl_to_str), .q_o(lvl_str));

   // async buffer
   logic          wr_valid, wr_ready, rd_valid, rd_ready;
   logic [FW-1:0] wr_data, rd_data;

   vsi_afifo #(.W(FW), .AW(FIFO_AW)) u_fifo (
      .wr_clk_i   (vid_clk_i),
      .wr_rst_i   (vrst),
      .wr_valid_i (wr_valid),
      .wr_data_i  (wr_data),
      .wr_ready_o (wr_ready),
      .rd_clk_i   (clk_i),
      .rd_rst_i   (rst),
      .rd_valid_o (rd_valid),
      .rd_data_o  (rd_data),
      .rd_ready_i (rd_ready)
   );

   // video domain frame tracking; last sample is held back so eop can be set on it
   vsi_frame_t        state, next_state;
   logic [DATA_W-1:0] held, next_held;
   logic [STD_W-1:0]  std_hold, next_std_hold;
   logic [DIV_W-1:0]  div_val, next_div_val, cnt, next_cnt;
   logic              held_v, next_held_v, held_sop, next_held_sop, first, next_first;
   logic              ovf_tog, next_ovf_tog, std_tog, next_std_tog, div_tog_d, seen, next_seen;
   logic              next_sof, next_refclk;
   logic              vs_rise, boundary, start;
   logic [DIV_W-1:0]  div_reg;

   assign vs_rise  = v_vs & ~v_vs_d;
   assign boundary = vs_rise | (v_lock_d & ~v_lock);
   assign start    = vs_rise & v_lock & v_go;

   always_comb
   begin
      next_state    = state;
      next_held     = held;
      next_held_v   = held_v;
      next_held_sop = held_sop;
      next_first    = first;
      wr_valid      = 1'h0;
      wr_data       = {held_sop, 1'h0, held};
      case (state)
         VSI_WAIT:
         begin
            if (start)
            begin
               next_state = VSI_FRAME;
               next_first = 1'h1;
            end
         end
         VSI_FRAME:
         begin
            if (boundary)
            begin
               wr_valid    = held_v;
               wr_data     = {held_sop, 1'h1, held};
               next_held_v = 1'h0;
               next_first  = start;
               if (!start)
                  next_state = VSI_WAIT;
               else if (v_dv)
               begin
                  next_held     = v_data;
                  next_held_sop = 1'h1;
                  next_held_v   = 1'h1;
                  next_first    = 1'h0;
               end
            end
            else if (v_dv)
            begin
               wr_valid      = held_v;
               next_held     = v_data;
               next_held_sop = first;
               next_held_v   = 1'h1;
               next_first    = 1'h0;
            end
         end
         default: next_state = VSI_WAIT;
      endcase
      // a sample refused by a full buffer is lost and flagged
      next_ovf_tog  = ovf_tog ^ (wr_valid & ~wr_ready);
      next_std_hold = v_std;
      next_std_tog  = std_tog ^ (v_std != std_hold);
      next_div_val  = (v_div_tog != div_tog_d) ? div_reg : div_val;
      next_cnt      = (div_val < DIV_TWO || cnt >= div_val - DIV_ONE) ? '0 : cnt + DIV_ONE;
      next_refclk   = (div_val >= DIV_TWO) && (next_cnt < (div_val >> 1));
      next_sof      = vs_rise & v_lock;
      next_seen     = v_lock & (seen | vs_rise);
   end

   always_ff @(posedge vid_clk_i or posedge vrst)
   begin
      if (vrst)
      begin
         state               <= VSI_WAIT;
         held                <= '0;
         held_v              <= 1'h0;
         held_sop            <= 1'h0;
         first               <= 1'h0;
         ovf_tog             <= 1'h0;
         std_hold            <= '0;
         std_tog             <= 1'h0;
         div_val             <= '0;
         div_tog_d           <= 1'h0;
         cnt                 <= '0;
         refclk_div_o        <= 1'h0;
         frame_start_o       <= 1'h0;
         seen                <= 1'h0;
         frame_start_valid_o <= 1'h0;
      end
      else
      begin
         state               <= next_state;
         held                <= next_held;
         held_v              <= next_held_v;
         held_sop            <= next_held_sop;
         first               <= next_first;
         ovf_tog             <= next_ovf_tog;
         std_hold            <= next_std_hold;
         std_tog             <= next_std_tog;
         div_val             <= next_div_val;
         div_tog_d           <= v_div_tog;
         cnt                 <= next_cnt;
         refclk_div_o        <= next_refclk;
         frame_start_o       <= next_sof;
         seen                <= next_seen;
         frame_start_valid_o <= next_seen;
      end
   end

   assign to_str = {std_tog, ovf_tog};

   // stream domain: control registers and output stage
   logic [VSI_CTRL_W-1:0] ctrl, next_ctrl;
   logic [DIV_W-1:0]      next_div_reg;
   logic [STD_W-1:0]      std_reg, next_std_reg;
   logic [VSI_BUS_W-1:0]  next_rdata, status_word;
   logic [1:0]            tog_d;
   logic                  div_tog, next_div_tog, ovf_st, next_ovf_st, pend, next_pend, lock_prev;
   logic                  next_irq, ovf_edge, std_edge, wr_hit;
   logic [DATA_W-1:0]     next_pix;
   logic                  next_sop, next_eop, next_bv;

   assign ovf_edge    = from_vid[0] ^ tog_d[0];
   assign std_edge    = from_vid[1] ^ tog_d[1];
   assign wr_hit      = USE_CTRL & control_write_strobe_i;
   assign rd_ready    = ~stream_beat_valid_o | stream_sink_ready_i;
   assign to_vid      = {div_tog, USE_CTRL & ovf_st, ctrl[VSI_CTRL_GO]};
   assign status_word = VSI_BUS_W'({lvl_str[3], lvl_str[2], lvl_str[1], ovf_st, lvl_str[0]});

   always_comb
   begin
      next_ctrl    = ctrl;
      next_div_reg = div_reg;
      next_div_tog = div_tog;
      next_std_reg = std_edge ? std_hold : std_reg;
      next_ovf_st  = ovf_st;
      next_pend    = pend;
      next_rdata   = control_read_bus_o;
      // word offset decode; writes clear first so a same-cycle event wins
      if (wr_hit && control_word_offset_i == VSI_OFS_CTRL)
         next_ctrl = control_write_bus_i[VSI_CTRL_W-1:0];
      else if (wr_hit && control_word_offset_i == VSI_OFS_STAT)
         next_ovf_st = ovf_st & ~control_write_bus_i[VSI_ST_OVF];
      else if (wr_hit && control_word_offset_i == VSI_OFS_IRQ)
         next_pend = pend & ~control_write_bus_i[VSI_IRQ_UPD];
      else if (wr_hit && control_word_offset_i == VSI_OFS_DIV)
      begin
         next_div_reg = control_write_bus_i[DIV_W-1:0];
         next_div_tog = ~div_tog;
      end
      if (ovf_edge)
         next_ovf_st = 1'h1;
      if (ovf_edge || lvl_str[0] != lock_prev)
         next_pend = 1'h1;
      next_irq = USE_CTRL & next_pend & next_ctrl[VSI_CTRL_IRQ_EN];
      if (USE_CTRL && control_read_strobe_i)
      begin
         if (control_word_offset_i == VSI_OFS_CTRL)
            next_rdata = VSI_BUS_W'(ctrl);
         else if (control_word_offset_i == VSI_OFS_STAT)
            next_rdata = status_word;
         else if (control_word_offset_i == VSI_OFS_IRQ)
            next_rdata = VSI_BUS_W'(pend);
         else if (control_word_offset_i == VSI_OFS_STD)
            next_rdata = VSI_BUS_W'(std_reg);
         else if (control_word_offset_i == VSI_OFS_DIV)
            next_rdata = VSI_BUS_W'(div_reg);
         else
            next_rdata = '0;
      end
      // output stage reloads only when empty or taken, so data never moves under a stall
      next_pix = stream_pixel_out_o;
      next_sop = stream_frame_first_o;
      next_eop = stream_frame_last_o;
      next_bv  = stream_beat_valid_o & ~stream_sink_ready_i;
      if (rd_ready && rd_valid)
      begin
         next_pix = rd_data[DATA_W-1:0];
         next_eop = rd_data[DATA_W];
         next_sop = rd_data[DATA_W+1];
         next_bv  = 1'h1;
      end
   end

   always_ff @(posedge clk_i or posedge rst)
   begin
      if (rst)
      begin
         ctrl                 <= USE_CTRL ? VSI_CTRL_RST_ON : VSI_CTRL_RST_OFF;
         div_reg              <= '0;
         div_tog              <= 1'h0;
         std_reg              <= '0;
         ovf_st               <= 1'h0;
         pend                 <= 1'h0;
         lock_prev            <= 1'h0;
         tog_d                <= 2'h0;
         control_read_bus_o   <= '0;
         status_update_irq_o  <= 1'h0;
         stream_pixel_out_o   <= '0;
         stream_frame_first_o <= 1'h0;
         stream_frame_last_o  <= 1'h0;
         stream_beat_valid_o  <= 1'h0;
      end
      else
      begin
         ctrl                 <= next_ctrl;
         div_reg              <= next_div_reg;
         div_tog              <= next_div_tog;
         std_reg              <= next_std_reg;
         ovf_st               <= next_ovf_st;
         pend                 <= next_pend;
         lock_prev            <= lvl_str[0];
         tog_d                <= from_vid;
         control_read_bus_o   <= next_rdata;
         status_update_irq_o  <= next_irq;
         stream_pixel_out_o   <= next_pix;
         stream_frame_first_o <= next_sop;
         stream_frame_last_o  <= next_eop;
         stream_beat_valid_o  <= next_bv;
      end
   end

   // checks
   property p_stall_hold;
      @(posedge clk_i) disable iff (rst)
      stream_beat_valid_o && !stream_sink_ready_i |=> stream_beat_valid_o && $stable(stream_pixel_out_o)
         && $stable(stream_frame_first_o) && $stable(stream_frame_last_o);
   endproperty
   a_stall_hold: assert property (p_stall_hold) else $error("beat changed while stalled");

   property p_read_std;
      @(posedge clk_i) disable iff (rst)
      USE_CTRL && control_read_strobe_i && control_word_offset_i == VSI_OFS_STD
         |=> control_read_bus_o == VSI_BUS_W'($past(std_reg));
   endproperty
   a_read_std: assert property (p_read_std) else $error("standard read mismatch");

   property p_write_div;
      @(posedge clk_i) disable iff (rst)
      wr_hit && control_word_offset_i == VSI_OFS_DIV
         |=> div_reg == $past(control_write_bus_i[DIV_W-1:0]) && div_tog != $past(div_tog);
   endproperty
   a_write_div: assert property (p_write_div) else $error("divider write lost");

   property p_ovf_sticky;
      @(posedge clk_i) disable iff (rst)
      ovf_edge |=> ovf_st ##1 (ovf_st || $past(wr_hit));
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow not held");

   property p_irq_on_lock;
      @(posedge clk_i) disable iff (rst)
      USE_CTRL && lvl_str[0] != lock_prev && ctrl[VSI_CTRL_IRQ_EN] && !wr_hit |=> status_update_irq_o && pend;
   endproperty
   a_irq_on_lock: assert property (p_irq_on_lock) else $error("no interrupt after status change");

   property p_sof_pulse;
      @(posedge vid_clk_i) disable iff (vrst)
      vs_rise && v_lock |=> frame_start_o ##1 !frame_start_o;
   endproperty
   a_sof_pulse: assert property (p_sof_pulse) else $error("frame start pulse wrong");

   property p_sofv_drop;
      @(posedge vid_clk_i) disable iff (vrst)
      !v_lock |=> !frame_start_valid_o && !frame_start_o;
   endproperty
   a_sofv_drop: assert property (p_sofv_drop) else $error("frame start valid without lock");

   property p_eop_push;
      @(posedge vid_clk_i) disable iff (vrst)
      state == VSI_FRAME && boundary && held_v |-> wr_valid && wr_data[DATA_W] ##1 !held_v || held_sop;
   endproperty
   a_eop_push: assert property (p_eop_push) else $error("frame end not marked");

endmodule

/* File: verification/tb_top.sv */
module tb_top import vsi_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_i = 1'b0, reset_i = 1'b1, rdy = 1'b0, rd = 1'b0, wr = 1'b0, plane = 1'b0, chk_on = 1'b1, hold = 1'b0;
   logic [3:0] ofs = '0;
   logic [31:0] wdat = '0, rdat, rv, d;
   logic [2:0] std = '0;
   logic vclk, vval, lock, fld, hs, vsn, sop, eop, val, irq, ovf, rclk, fs, fsv;
   logic [19:0] vdat, pix;
   logic [21:0] exq[$];
   int error_cnt = 0, num_checks = 0, fs_cnt = 0, hi = 0;

   always #10 clk_i = ~clk_i;

   vsi_vid_model i_vsi_vid_model (.vid_clk_o(vclk), .sample_o(vdat), .valid_o(vval), .lock_o(lock),
      .field_o(fld), .hsync_o(hs), .vsync_o(vsn));

   vsi_top i_vsi_top (.clk_i(clk_i), .reset_i(reset_i), .vid_clk_i(vclk), .vid_sample_i(vdat),
      .sample_valid_i(vval), .vid_lock_i(lock), .vid_standard_i(std), .field_i(fld), .hsync_i(hs),
      .vsync_i(vsn), .plane_format_select_i(plane), .control_word_offset_i(ofs),
      .control_read_strobe_i(rd), .control_write_strobe_i(wr), .control_write_bus_i(wdat),
      .control_read_bus_o(rdat), .status_update_irq_o(irq), .stream_pixel_out_o(pix),
      .stream_frame_first_o(sop), .stream_frame_last_o(eop), .stream_beat_valid_o(val),
      .stream_sink_ready_i(rdy), .overflow_o(ovf), .refclk_div_o(rclk), .frame_start_o(fs),
      .frame_start_valid_o(fsv));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cw(input logic [3:0] o, input logic [31:0] v);
      @(negedge clk_i);
      ofs  = o;
      wdat = v;
      wr   = 1'b1;
      @(negedge clk_i);
      wr   = 1'b0;
   endtask

   task automatic cr(input logic [3:0] o, output logic [31:0] v);
      @(negedge clk_i);
      ofs = o;
      rd  = 1'b1;
      @(negedge clk_i);
      rd  = 1'b0;
      v   = rdat;
   endtask

   // expected beats only while the stream is being checked
   task automatic frame(input int n);
      logic [19:0] s;
      i_vsi_vid_model.vs();
      for (int i = 0; i < n; i++)
      begin
         s = 20'($urandom);
         if (chk_on)
            exq.push_back({i == 0, i == n - 1, s});
         i_vsi_vid_model.put(s);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(negedge clk_i)
      rdy <= hold ? 1'b0 : 1'($urandom);

   always @(posedge clk_i)
      if (!reset_i && chk_on && val === 1'b1 && rdy)
         chk(32'({sop, eop, pix}), exq.size() != 0 ? 32'(exq.pop_front()) : 'x);

   always @(posedge fs)
      fs_cnt++;

   initial
   begin
      void'($urandom(32'h348d793d));
      plane = 1'($urandom);
      std   = 3'($urandom);
      repeat (20) @(negedge clk_i);
      reset_i = 1'b0;
      repeat (4) @(negedge clk_i);
      cr(VSI_OFS_CTRL, rv);
      chk(rv, 32'h0);
      cw(VSI_OFS_CTRL, 32'h3);
      cr(VSI_OFS_CTRL, rv);
      chk(rv, 32'h3);
      d = 32'($urandom_range(400, 2)); // below 2 the divided clock stays low, long ratios cost run time
      cw(VSI_OFS_DIV, d);
      cr(VSI_OFS_DIV, rv);
      chk(rv, d);
      cr(4'hf, rv);
      chk(rv, 32'h0);
      i_vsi_vid_model.lk(1'b1);
      repeat (12) @(negedge clk_i);
      chk(irq, 32'h1);
      cw(VSI_OFS_IRQ, 32'h1);
      repeat (2) @(negedge clk_i);
      chk(irq, 32'h0);
      cr(VSI_OFS_STAT, rv);
      chk(rv & 32'h1f, (32'(plane) << 3) | 32'h1);
      cr(VSI_OFS_STD, rv);
      chk(rv, 32'(std));
      // skip the first divider period, which may start part way through
      repeat (2) @(posedge rclk);
      repeat (d)
      begin
         @(negedge vclk);
         hi += int'(rclk);
      end
      chk(32'(hi), d >> 1);
      chk(rclk, 32'h0);
      @(negedge vclk);
      chk(rclk, 32'h1);
      // a single-sample frame sits between two longer ones
      frame(5);
      frame(1);
      frame(7);
      i_vsi_vid_model.vs();
      repeat (200) @(negedge clk_i);
      chk(32'(exq.size()), 32'h0);
      chk_on = 1'b0;
      hold   = 1'b1;
      frame(40);
      repeat (60) @(negedge clk_i);
      chk(ovf, 32'h1);
      cr(VSI_OFS_STAT, rv);
      chk(rv & 32'h2, 32'h2);
      chk(irq, 32'h1);
      cw(VSI_OFS_STAT, 32'h2);
      cr(VSI_OFS_STAT, rv);
      chk(rv & 32'h2, 32'h0);
      repeat (8) @(negedge clk_i);
      chk(ovf, 32'h0);
      chk(32'(fs_cnt), 32'h5);
      chk(fsv, 32'h1);
      i_vsi_vid_model.lk(1'b0);
      repeat (10) @(negedge clk_i);
      chk(fsv, 32'h0);
      cr(VSI_OFS_STAT, rv);
      chk(rv & 32'h1, 32'h0);
      end_sim();
   end

   initial
   begin
      #400us;
      error_cnt++;
      end_sim();
   end
endmodule

/* File: verification/vsi_vid_model.sv */
module vsi_vid_model #(
   parameter int unsigned W = 20
)(
   // video side lines
   output logic         vid_clk_o,
   output logic [W-1:0] sample_o,
   output logic         valid_o,
   output logic         lock_o,
   output logic         field_o,
   output logic         hsync_o,
   output logic         vsync_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      vid_clk_o = 1'b0;
      sample_o  = '0;
      valid_o   = 1'b0;
      lock_o    = 1'b0;
      field_o   = 1'b0; // progressive, field held low
      hsync_o   = 1'b0;
      vsync_o   = 1'b0;
   end

   // free running, unrelated in phase to the stream clock
   always #18.5 vid_clk_o = ~vid_clk_o;

   // all lines change on the falling video edge
   task automatic lk(input logic v);
      @(negedge vid_clk_o);
      lock_o = v;
   endtask

   task automatic vs();
      @(negedge vid_clk_o);
      vsync_o = 1'b1;
      hsync_o = 1'b1;
      repeat (2) @(negedge vid_clk_o);
      vsync_o = 1'b0;
      hsync_o = 1'b0;
      repeat (4) @(negedge vid_clk_o);
   endtask

   // data line shows the inverse once the qualifier drops
   task automatic put(input logic [W-1:0] d);
      @(negedge vid_clk_o);
      valid_o  = 1'b1;
      sample_o = d;
      @(negedge vid_clk_o);
      valid_o  = 1'b0;
      sample_o = ~d;
   endtask
endmodule
